/* hdl/general_line_decode.sv */
`timescale 1ns/100ps
`include "general_line_params.svh"
// How it works
// - Bits 21-20 pick line 0 second half: default level, reserved, low, high.
// - Bit 19 drives line 1 in quarters 1-2, bit 18 in quarters 3-4.
// - Bit 17 drives line 2 first half, bit 16 second half.
// - Bit 15 drives line 3 first half, bit 14 second half.
// - Bit 11 drives line 5 in quarters 1-2, bit 10 in quarters 3-4.
// - Function bit 0 makes line 4 an output; bit 13 sets its first half.
// - In wait mode bit 13 picks read capture: next quarter 1 or quarter 3.
// - With line 4 an output, bit 12 sets its second-half level.
// - In wait mode bit 12 turns wait detection off or on.
// - Wait asserted with detection on freezes lines 0-5 until it drops; capture stays low.
// - Words are 32 bits, held in a 64-entry pattern memory.
// - With divider 2 only quarters 1 and 3 exist; halves apply.
module general_line_decode (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [`ADDR_W-1:0] addr,
  input  wire logic [`WORD_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [`WORD_W-1:0] rdata,
  input  wire logic              external_wait_in,
  output logic                   general_line_0,
  output logic                   general_line_1,
  output logic                   general_line_2,
  output logic                   general_line_3,
  output logic                   general_line_4,
  output logic                   general_line_4_oe,
  output logic                   general_line_5,
  output logic                   data_capture
);
  general_line_pkg::decode_state_t s_q;
  general_line_pkg::decode_state_t s_d;
  logic                            frozen;
  logic                            restart;
  logic                            update;
  logic                            sh_d;
  logic                            sh_q;
  logic [1:0]                      quarter_q;

  // --------------------------------------------------------------------------
  // Phase helpers
  // --------------------------------------------------------------------------

  // Quarter phase (0..3 for T1..T4) reached by a given count at a divider.
  function automatic logic [1:0] quarter_of(input logic [`CNT_W-1:0] cnt,
                                            input logic [1:0] div_sel);
    logic [1:0] q;
    q = 2'h0;
    case (div_sel)
      `DIV_SEL_2: q = cnt[0] ? 2'h2 : 2'h0;
      `DIV_SEL_4: q = cnt[1:0];
      default:    q = cnt[2:1];
    endcase
    return q;
  endfunction

  // Last count of one bus clock cycle for a divider setting.
  function automatic logic [`CNT_W-1:0] last_of(input logic [1:0] div_sel);
    logic [`CNT_W-1:0] l;
    l = `LAST_DIV_8;
    case (div_sel)
      `DIV_SEL_2: l = `LAST_DIV_2;
      `DIV_SEL_4: l = `LAST_DIV_4;
      default:    l = `LAST_DIV_8;
    endcase
    return l;
  endfunction

  // Second-half decode of line 0; the reserved code keeps the present level.
  function automatic logic line0_of(input logic [1:0] code, input logic dflt,
                                    input logic cur);
    logic v;
    v = cur;
    case (code)
      `L0_LOW:     v = 1'h0;
      `L0_HIGH:    v = 1'h1;
      `L0_DEFAULT: v = dflt;
      default:     v = cur;
    endcase
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // Wait freeze
  // --------------------------------------------------------------------------

  // Only the second synchroniser stage is looked at. The two-cycle lag means a
  // wait must be raised at least two clocks before the phase it must stop.
  assign frozen = s_q.run && s_q.fsel4 && s_q.word[`W_L4_SH] && s_q.wait_s2;

  // A software start overrides a freeze. Without this the sequencer would jump
  // back to the start word while the lines stayed on the old word.
  assign restart = wr_en && (addr == `REG_CTRL) && wdata[`CTRL_RUN];

  // --------------------------------------------------------------------------
  // Sequencer, register port and line 0
  // --------------------------------------------------------------------------

  // Sequencing runs first so a software write in the same cycle wins over
  // the end-of-range stop.
  always_comb begin
    s_d         = s_q;
    s_d.capture = 1'h0;
    s_d.rdata   = '0;
    s_d.wait_s1 = external_wait_in;
    s_d.wait_s2 = s_q.wait_s1;
    if (s_q.run && !frozen) begin
      if (s_q.cnt == last_of(s_q.div_sel)) begin
        s_d.cnt = '0;
        if (s_q.rd_acc && s_q.fsel4 && !s_q.word[`W_L4_FH]) begin
          s_d.capture = 1'h1;
        end
        if (s_q.ptr == s_q.end_idx) begin
          s_d.run = 1'h0;
        end else begin
          s_d.ptr  = s_q.ptr + 6'h01;
          s_d.word = s_q.mem[s_q.ptr + 6'h01];
        end
      end else begin
        s_d.cnt = s_q.cnt + 3'h1;
        if (s_q.rd_acc && s_q.fsel4 && s_q.word[`W_L4_FH]
            && quarter_of(s_q.cnt + 3'h1, s_q.div_sel) == 2'h2
            && quarter_of(s_q.cnt, s_q.div_sel) != 2'h2) begin
          s_d.capture = 1'h1;
        end
      end
    end
    if (wr_en) begin
      case (addr)
        `REG_CTRL: begin
          s_d.dflt0   = wdata[`CTRL_DFLT0];
          s_d.fsel4   = wdata[`CTRL_FSEL4];
          s_d.rd_acc  = wdata[`CTRL_READ];
          s_d.div_sel = wdata[`CTRL_DIV_HI:`CTRL_DIV_LO];
          s_d.run     = wdata[`CTRL_RUN];
          s_d.capture = 1'h0;
          if (wdata[`CTRL_RUN]) begin
            s_d.ptr  = s_q.start_idx;
            s_d.cnt  = '0;
            s_d.word = s_q.mem[s_q.start_idx];
          end
        end
        `REG_INDEX: s_d.load_idx = wdata[`IDX_W-1:0];
        `REG_WORD: begin
          s_d.mem[s_q.load_idx] = wdata;
          s_d.load_idx          = s_q.load_idx + 6'h01;
        end
        `REG_RANGE: begin
          s_d.start_idx = wdata[`IDX_W-1:0];
          s_d.end_idx   = wdata[`RANGE_END_HI:`RANGE_END_LO];
        end
        default: s_d.load_idx = s_q.load_idx;
      endcase
    end
    if (rd_en) begin
      case (addr)
        `REG_CTRL:   s_d.rdata = {26'h0, s_q.div_sel, s_q.rd_acc, s_q.fsel4,
                                  s_q.dflt0, s_q.run};
        `REG_INDEX:  s_d.rdata = {26'h0, s_q.load_idx};
        `REG_WORD:   s_d.rdata = s_q.mem[s_q.load_idx];
        `REG_RANGE:  s_d.rdata = {18'h0, s_q.end_idx, 2'h0, s_q.start_idx};
        `REG_STATUS: s_d.rdata = {18'h0, quarter_q, 2'h0, s_q.ptr, 1'h0,
                                  s_q.wait_s2, frozen, s_q.run};
        default:     s_d.rdata = '0;
      endcase
    end
    // Line 0 uses the same load condition as the drivers. It is written out
    // here because update and sh_d are built from s_d and would form a loop.
    if (s_d.run && (!frozen || restart)) begin
      if (quarter_of(s_d.cnt, s_d.div_sel) >= 2'h2) begin
        s_d.line0 = line0_of(s_d.word[`W_L0_HI:`W_L0_LO], s_d.dflt0, s_q.line0);
      end else begin
        s_d.line0 = s_d.dflt0;
      end
    end
  end

  // Lines are loaded from the next phase so they line up with the count.
  assign update    = s_d.run && (!frozen || restart);
  assign sh_d      = quarter_of(s_d.cnt, s_d.div_sel) >= 2'h2;
  assign quarter_q = quarter_of(s_q.cnt, s_q.div_sel);
  assign sh_q      = quarter_q >= 2'h2;

  // Single state register.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Half-cycle line drivers
  // --------------------------------------------------------------------------

  // Line 1.
  half_line u_line1 (
    .clk          (clk),
    .rst          (rst),
    .update       (update),
    .first_level  (s_d.word[`W_L1_FH]),
    .second_level (s_d.word[`W_L1_SH]),
    .second_half  (sh_d),
    .level        (general_line_1)
  );

  // Line 2.
  half_line u_line2 (
    .clk          (clk),
    .rst          (rst),
    .update       (update),
    .first_level  (s_d.word[`W_L2_FH]),
    .second_level (s_d.word[`W_L2_SH]),
    .second_half  (sh_d),
    .level        (general_line_2)
  );

  // Line 3.
  half_line u_line3 (
    .clk          (clk),
    .rst          (rst),
    .update       (update),
    .first_level  (s_d.word[`W_L3_FH]),
    .second_level (s_d.word[`W_L3_SH]),
    .second_half  (sh_d),
    .level        (general_line_3)
  );

  // Line 4 drives low while the pin serves as the wait input.
  half_line u_line4 (
    .clk          (clk),
    .rst          (rst),
    .update       (update),
    .first_level  (!s_d.fsel4 && s_d.word[`W_L4_FH]),
    .second_level (!s_d.fsel4 && s_d.word[`W_L4_SH]),
    .second_half  (sh_d),
    .level        (general_line_4)
  );

  // Line 5.
  half_line u_line5 (
    .clk          (clk),
    .rst          (rst),
    .update       (update),
    .first_level  (s_d.word[`W_L5_FH]),
    .second_level (s_d.word[`W_L5_SH]),
    .second_half  (sh_d),
    .level        (general_line_5)
  );

  assign general_line_0    = s_q.line0;
  assign general_line_4_oe = !s_q.fsel4;
  assign data_capture      = s_q.capture;
  assign rdata             = s_q.rdata;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  line0_low_a: assert property (s_q.run && sh_q && s_q.word[21:20] == 2'h2
    |-> !general_line_0) else $error("line 0 not low for code 10");
  line0_default_a: assert property (s_q.run && !sh_q |-> general_line_0 == s_q.dflt0)
    else $error("line 0 first half not at default level");
  line1_level_a: assert property (s_q.run && !frozen
    |-> general_line_1 == (sh_q ? s_q.word[18] : s_q.word[19]))
    else $error("line 1 level does not follow word");
  line2_level_a: assert property (s_q.run && !frozen
    |-> general_line_2 == (sh_q ? s_q.word[16] : s_q.word[17]))
    else $error("line 2 level does not follow word");
  line3_level_a: assert property (s_q.run && !frozen
    |-> general_line_3 == (sh_q ? s_q.word[14] : s_q.word[15]))
    else $error("line 3 level does not follow word");
  line5_level_a: assert property (s_q.run && !frozen
    |-> general_line_5 == (sh_q ? s_q.word[10] : s_q.word[11]))
    else $error("line 5 level does not follow word");
  line4_output_a: assert property (s_q.run && !frozen && !s_q.fsel4
    |-> general_line_4_oe && general_line_4 == (sh_q ? s_q.word[12] : s_q.word[13]))
    else $error("line 4 output level wrong");
  // A pulse at quarter 1 belongs to the word that has just ended, so its select
  // bit is looked up one cycle back.
  capture_point_a: assert property (data_capture
    |-> s_q.fsel4 && (s_q.word[13] && quarter_q == 2'h2
                      || !$past(s_q.word[13]) && quarter_q == 2'h0))
    else $error("read capture at wrong quarter");
  wait_freeze_a: assert property (frozen && !restart
    |=> $stable(s_q.cnt) && $stable(general_line_0) && $stable(general_line_1)
        && $stable(general_line_4) && $stable(general_line_5))
    else $error("outputs moved during wait");
  wait_off_a: assert property (s_q.run && !s_q.word[12] |-> !frozen)
    else $error("wait honoured while disabled");
  div2_phase_a: assert property (s_q.div_sel == 2'h0
    |-> quarter_q == 2'h0 || quarter_q == 2'h2)
    else $error("quarter 2 or 4 with divider 2");

  freeze_seen_c: cover property (frozen ##1 !frozen);
  capture_seen_c: cover property (data_capture);
  range_done_c: cover property (s_q.run ##1 !s_q.run);
  wait_ignored_c: cover property (s_q.run && s_q.fsel4 && !s_q.word[12] && s_q.wait_s2);
endmodule

/* hdl/general_line_params.svh */
`ifndef GENERAL_LINE_PARAMS_SVH
`define GENERAL_LINE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define WORD_W       32
`define MEM_DEPTH    64
`define IDX_W        6
`define ADDR_W       5
`define CNT_W        3

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define REG_CTRL     5'h00
`define REG_INDEX    5'h04
`define REG_WORD     5'h08
`define REG_RANGE    5'h0C
`define REG_STATUS   5'h10

// ----------------------------------------------------------------------------
// Control and range register fields, reset value zero
// ----------------------------------------------------------------------------
`define CTRL_RUN     0
`define CTRL_DFLT0   1
`define CTRL_FSEL4   2
`define CTRL_READ    3
`define CTRL_DIV_LO  4
`define CTRL_DIV_HI  5
`define CTRL_RESET   32'h0000_0000
`define RANGE_END_LO 8
`define RANGE_END_HI 13

// ----------------------------------------------------------------------------
// Bus clock divider codes and last count of each
// ----------------------------------------------------------------------------
`define DIV_SEL_2    2'h0
`define DIV_SEL_4    2'h1
`define DIV_SEL_8    2'h2
`define LAST_DIV_2   3'h1
`define LAST_DIV_4   3'h3
`define LAST_DIV_8   3'h7

// ----------------------------------------------------------------------------
// Micro-instruction word bit positions
// ----------------------------------------------------------------------------
`define W_L0_HI      21
`define W_L0_LO      20
`define W_L1_FH      19
`define W_L1_SH      18
`define W_L2_FH      17
`define W_L2_SH      16
`define W_L3_FH      15
`define W_L3_SH      14
`define W_L4_FH      13
`define W_L4_SH      12
`define W_L5_FH      11
`define W_L5_SH      10

// ----------------------------------------------------------------------------
// Line 0 second-half codes
// ----------------------------------------------------------------------------
`define L0_DEFAULT   2'h0
`define L0_RESERVED  2'h1
`define L0_LOW       2'h2
`define L0_HIGH      2'h3

`endif

/* hdl/general_line_pkg.sv */
package general_line_pkg;
  `include "general_line_params.svh"

  // --------------------------------------------------------------------------
  // State of the decoder.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`MEM_DEPTH-1:0][`WORD_W-1:0] mem;
    logic [`WORD_W-1:0]                 word;
    logic [`WORD_W-1:0]                 rdata;
    logic [`IDX_W-1:0]                  load_idx;
    logic [`IDX_W-1:0]                  start_idx;
    logic [`IDX_W-1:0]                  end_idx;
    logic [`IDX_W-1:0]                  ptr;
    logic [`CNT_W-1:0]                  cnt;
    logic [1:0]                         div_sel;
    logic                               run;
    logic                               dflt0;
    logic                               fsel4;
    logic                               rd_acc;
    logic                               line0;
    logic                               capture;
    logic                               wait_s1;
    logic                               wait_s2;
  } decode_state_t;

  // --------------------------------------------------------------------------
  // State of one half-cycle line driver.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic level;
  } half_line_state_t;
endpackage

/* hdl/half_line.sv */
`timescale 1ns/100ps
module half_line (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic update,
  input  wire logic first_level,
  input  wire logic second_level,
  input  wire logic second_half,
  output logic      level
);
  general_line_pkg::half_line_state_t s_q;
  general_line_pkg::half_line_state_t s_d;

  // The level only moves when the sequencer enters a new phase, so it stays
  // flat for the whole half cycle.
  always_comb begin
    s_d = s_q;
    if (update) begin
      s_d.level = second_half ? second_level : first_level;
    end
  end

  // Plain register for the line level.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;
endmodule

/* testbench/tb_upm_word_general_line_decode.sv */
`timescale 1ns/100ps
`include "general_line_params.svh"
module tb_upm_word_general_line_decode;
  logic                clk;
  logic                rst;
  logic [`ADDR_W-1:0]  addr;
  logic [`WORD_W-1:0]  wdata;
  logic [`WORD_W-1:0]  rdata;
  logic                wr_en;
  logic                rd_en;
  logic                external_wait_in;
  logic                general_line_0;
  logic                general_line_1;
  logic                general_line_2;
  logic                general_line_3;
  logic                general_line_4;
  logic                general_line_4_oe;
  logic                general_line_5;
  logic                data_capture;
  logic                stall_go;
  logic [7:0]          stall_len;
  logic [5:0]          lines;
  logic [31:0]         q[$];
  int                  miscompares;
  int                  cmp_count;

  assign lines = {general_line_5, general_line_4, general_line_3,
                  general_line_2, general_line_1, general_line_0};

  general_line_decode u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .external_wait_in(external_wait_in),
    .general_line_0(general_line_0), .general_line_1(general_line_1),
    .general_line_2(general_line_2), .general_line_3(general_line_3),
    .general_line_4(general_line_4), .general_line_4_oe(general_line_4_oe),
    .general_line_5(general_line_5), .data_capture(data_capture));

  wait_source u_far (.clk(clk), .rst(rst), .stall_go(stall_go), .stall_len(stall_len),
    .wait_out(external_wait_in));

  // ----------------------------------------------------------------------------
  // Clock, verdict and watchdog
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under two thousand cycles; this allows ten times that.
  initial begin
    #(40 * 20000);
    miscompares++;
    $display("unexpected watchdog expiry at %0t", $time);
    stop_test();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------------
  // Register bus master: strobes rise and fall just after rising edges
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // ----------------------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] mk(input logic [1:0] c, input logic [9:0] p);
    return {10'h000, c, p, 10'h000};
  endfunction

  // Line 0 first half is the default level; a reserved code keeps that level.
  function automatic logic [5:0] exp_l(input logic [31:0] w, input bit sh, dflt, fsel);
    logic l0;
    l0 = dflt;
    if (sh && w[21:20] == `L0_LOW) l0 = 1'b0;
    if (sh && w[21:20] == `L0_HIGH) l0 = 1'b1;
    return {sh ? w[10] : w[11], fsel ? 1'b0 : (sh ? w[12] : w[13]),
            sh ? w[14] : w[15], sh ? w[16] : w[17], sh ? w[18] : w[19], l0};
  endfunction

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic check_reset();
    logic [31:0] d;
    @(negedge clk);
    chk(lines, 32'h0);
    chk(general_line_4_oe, 32'h1);
    chk(data_capture, 32'h0);
    rd(`REG_CTRL, d);
    chk(d, `CTRL_RESET);
    wr(5'h14, 32'hFFFF_FFFF);
    rd(5'h14, d);
    chk(d, 32'h0);
    @(negedge clk);
    chk(rdata, 32'h0);
  endtask

  // Runs the queued words from index st and checks every cycle plus one after the end.
  task automatic run_words(input logic [5:0] st, input logic [1:0] div, input bit dflt,
                           input bit fsel, input bit rdb);
    int          per;
    int          n;
    int          k;
    bit          sh;
    bit          cap;
    logic [31:0] d;
    logic [5:0]  en;
    per = 2 << div;
    n   = q.size();
    en  = st + 6'(n - 1);
    wr(`REG_INDEX, {26'h0, st});
    foreach (q[i]) wr(`REG_WORD, q[i]);
    wr(`REG_RANGE, {18'h0, en, 2'h0, st});
    wr(`REG_CTRL, {26'h0, div, rdb, fsel, dflt, 1'b1});
    for (int j = 0; j <= n * per; j++) begin
      @(negedge clk);
      k   = (j < n * per) ? j / per : n - 1;
      sh  = (j < n * per) ? (j % per >= per / 2) : 1'b1;
      cap = 1'b0;
      for (int m = 0; m < n; m++) begin
        if (fsel && rdb && (q[m][13] ? j == m * per + per / 2 : j == (m + 1) * per)) cap = 1'b1;
      end
      chk(lines, exp_l(q[k], sh, dflt, fsel));
      chk(general_line_4_oe, {31'h0, ~fsel});
      chk(data_capture, {31'h0, cap});
    end
    rd(`REG_CTRL, d);
    chk(d, {26'h0, div, rdb, fsel, dflt, 1'b0});
  endtask

  // Wait held high with detection on: nothing moves until the far side lets go.
  task automatic freeze_test();
    logic [31:0] w;
    logic [31:0] d;
    logic [5:0]  held;
    int          pulses;
    w = mk(`L0_LOW, 10'h2AC);
    @(posedge clk);
    stall_go  <= 1'b1;
    stall_len <= 8'h28;
    @(posedge clk);
    stall_go  <= 1'b0;
    wr(`REG_INDEX, 32'h0);
    wr(`REG_WORD, w);
    wr(`REG_RANGE, 32'h0);
    wr(`REG_CTRL, {26'h0, `DIV_SEL_8, 1'b1, 1'b1, 1'b0, 1'b1});
    @(negedge clk);
    held = lines;
    repeat (6) begin
      @(negedge clk);
      chk(lines, held);
      chk(data_capture, 32'h0);
    end
    rd(`REG_STATUS, d);
    chk(d[2:0], 3'h7);
    pulses = 0;
    repeat (60) begin
      @(negedge clk);
      if (data_capture === 1'b1) pulses++;
    end
    chk(pulses, 1);
    chk(lines, exp_l(w, 1'b1, 1'b0, 1'b1));
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    rst         = 1'b1;
    addr        = '0;
    wdata       = '0;
    wr_en       = 1'b0;
    rd_en       = 1'b0;
    stall_go    = 1'b0;
    stall_len   = 8'h00;
    miscompares = 0;
    cmp_count   = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check_reset();
    q = '{mk(`L0_LOW, 10'h2AA), mk(`L0_HIGH, 10'h155), mk(`L0_DEFAULT, 10'h333),
          mk(`L0_RESERVED, 10'h0CC)};
    run_words(6'h00, `DIV_SEL_4, 1'b1, 1'b0, 1'b0);
    q = '{mk(`L0_HIGH, 10'h2AA), mk(`L0_DEFAULT, 10'h155), mk(`L0_RESERVED, 10'h3FF)};
    run_words(6'h3E, `DIV_SEL_2, 1'b0, 1'b0, 1'b0);
    q = '{mk(`L0_LOW, 10'h0F0), mk(`L0_HIGH, 10'h30F)};
    run_words(6'h05, `DIV_SEL_8, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    stall_go  <= 1'b1;
    stall_len <= 8'hC8;
    @(posedge clk);
    stall_go  <= 1'b0;
    q = '{mk(`L0_HIGH, 10'h208), mk(`L0_LOW, 10'h1C3)};
    run_words(6'h10, `DIV_SEL_4, 1'b1, 1'b1, 1'b1);
    freeze_test();
    stop_test();
  end
endmodule

/* testbench/wait_source.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Far-side peripheral that stalls an access with its wait line.
// ----------------------------------------------------------------------------
module wait_source (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       stall_go,
  input  wire logic [7:0] stall_len,
  output logic            wait_out
);
  logic [7:0] left_q;

  // A request loads the stall length; a short one answers promptly, a long one slowly.
  always_ff @(posedge clk) begin
    if (rst) begin
      left_q <= 8'h00;
    end else if (stall_go) begin
      left_q <= stall_len;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  // The line is always driven, so its negated level is a plain low, never a float.
  assign wait_out = (left_q != 8'h00);
endmodule
